/* File: fsp_regs.vh */
// Constants for the fuse, signature and parallel programming port block.
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
// Fuse high byte bit positions.
`define FSP_FH_DEBUG_BIT     3'd7
`define FSP_FH_SCAN_BIT      3'd6
`define FSP_FH_SERIAL_BIT    3'd5
`define FSP_FH_WDOG_BIT      3'd4
`define FSP_FH_KEEP_BIT      3'd3
`define FSP_FH_BOOT_HI_BIT   3'd2
`define FSP_FH_BOOT_LO_BIT   3'd1
`define FSP_FH_RSTVEC_BIT    3'd0
// Fuse low byte bit positions.
`define FSP_FL_DIV8_BIT      3'd7
`define FSP_FL_CLOCK_OUT_FUSE_BIT     3'd6
`define FSP_FL_SUT_HI_BIT    3'd5
`define FSP_FL_SUT_LO_BIT    3'd4
// Reset values, programmed reads as zero.
`define FSP_FH_RESET         8'h99
`define FSP_FL_RESET         8'h62
// Action select codes.
`define FSP_ACT_ADDR         2'h0
`define FSP_ACT_DATA         2'h1
`define FSP_ACT_CMD          2'h2
`define FSP_ACT_IDLE         2'h3
// Command codes.
`define FSP_CMD_ERASE        8'h80
`define FSP_CMD_WR_FUSE      8'h40
`define FSP_CMD_WR_LOCK      8'h20
`define FSP_CMD_RD_SIG       8'h08
`define FSP_CMD_RD_FUSE      8'h04
// Signature addresses.
`define FSP_SIG_ADDR0        8'h00
`define FSP_SIG_ADDR1        8'h01
`define FSP_SIG_ADDR2        8'h02
// Programming operation timing.
`define FSP_PROG_TIME_NS     4000
`define FSP_CLK_PERIOD_NS    25
`define FSP_PROG_CYCLES      ((`FSP_PROG_TIME_NS + `FSP_CLK_PERIOD_NS - 1) / `FSP_CLK_PERIOD_NS)
`endif

/* File: fsp_sync.v */
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module fsp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // Pins in, synchronised out
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* File: fsp_fuse_port.v */
// Fuse bytes, signature space and parallel programming port.
`timescale 1ns/1ps
`include "fsp_regs.vh"
module fsp_fuse_port #(
  parameter [7:0] SIG_BYTE0  = 8'hA5, // Arbitrary value.
  parameter [7:0] SIG_BYTE1  = 8'h5A, // Arbitrary value.
  parameter [7:0] SIG_BYTE2  = 8'h3C, // Arbitrary value.
  parameter [7:0] CALIB_BYTE = 8'h80,
  parameter       PROG_CYCLES = `FSP_PROG_CYCLES
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Mode
  input  wire       prog_mode,
  input  wire       serial_prog_mode,
  // Parallel port pins
  input  wire       crystal_in_strobe,
  input  wire       action_select_hi,
  input  wire       action_select_lo,
  input  wire       byte_select_one,
  input  wire       byte_select_two,
  input  wire       page_load_strobe,
  input  wire       write_n,
  input  wire       output_enable_n,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe,
  output reg        ready_busy_out,
  // Serial programming fuse write path
  input  wire       serial_fuse_wr,
  input  wire       serial_fuse_high,
  input  wire [7:0] serial_fuse_data,
  // Lock state and memory controls
  input  wire       lock_bit_one,
  output reg        chip_erase_pulse,
  output reg        eeprom_erase_pulse,
  output reg        page_load_pulse,
  // Latched fuse outputs
  output reg  [7:0] config_fuse_high,
  output reg  [7:0] config_fuse_low,
  output reg        debug_enable,
  output reg        scan_port_enable,
  output reg        serial_prog_enable,
  output reg        watchdog_force_on,
  output reg  [1:0] boot_size,
  output reg        reset_vector_select,
  output reg        clock_div_eight,
  output reg        clock_out_enable,
  output reg  [1:0] startup_time,
  output reg  [3:0] clock_source,
  output reg  [7:0] osc_calibration_reg
);
  localparam ST_IDLE = 1'b0;
  localparam ST_BUSY = 1'b1;
  // Pin idle levels: strobes low, active-low strobes high, lock bit unprogrammed.
  // Matching the edge detector resets keeps reset release from faking an edge.
  localparam [9:0] PIN_IDLE = 10'h00D;

  wire [9:0] pins_sync;
  wire       xtal_s = pins_sync[9];
  wire       xa_hi_s = pins_sync[8];
  wire       xa_lo_s = pins_sync[7];
  wire       bs1_s = pins_sync[6];
  wire       bs2_s = pins_sync[5];
  wire       pgl_s = pins_sync[4];
  wire       wr_n_s = pins_sync[3];
  wire       oe_n_s = pins_sync[2];
  wire       pm_s = pins_sync[1];
  wire       lock_s = pins_sync[0];
  wire [7:0] din_s;

  fsp_sync #(.WIDTH(10), .INIT(PIN_IDLE)) u_sync_ctl (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   ({crystal_in_strobe, action_select_hi, action_select_lo, byte_select_one,
                byte_select_two, page_load_strobe, write_n, output_enable_n, prog_mode, lock_bit_one}),
    .sync_out (pins_sync)
  );

  fsp_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_data (
    .clk      (clk),
    .rst_n    (rst_n),
    .pin_in   (data_in),
    .sync_out (din_s)
  );

  // Stored fuse cells; the outputs above hold the latched copies.
  reg  [7:0] fuse_high_cell_reg;
  reg  [7:0] fuse_low_cell_reg;
  reg  [7:0] cmd_reg;
  reg  [7:0] addr_lo_reg;
  reg  [7:0] data_lo_reg;
  reg        xtal_d_reg;
  reg        wr_n_d_reg;
  reg        oe_n_d_reg;
  reg        pgl_d_reg;
  reg        pm_d_reg;
  reg        state_reg;
  reg [15:0] busy_cnt_reg;
  reg        started_reg;

  wire xtal_rise = xtal_s & ~xtal_d_reg;
  wire wr_fall = ~wr_n_s & wr_n_d_reg;
  wire oe_fall = ~oe_n_s & oe_n_d_reg;
  wire pgl_rise = pgl_s & ~pgl_d_reg;
  wire pm_enter = pm_s & ~pm_d_reg;
  // Fuse writes are not accepted while a previous operation runs.
  // The lock pin reads 0 once programmed, so a fuse write needs it high.
  wire fuse_wr_ok = (state_reg == ST_IDLE) & lock_s;
  wire par_fuse_wr = pm_s & wr_fall & (cmd_reg == `FSP_CMD_WR_FUSE) & fuse_wr_ok;
  wire erase_go = pm_s & wr_fall & (cmd_reg == `FSP_CMD_ERASE) & (state_reg == ST_IDLE);
  // Serial writes need serial mode as well; a parallel write in the same cycle takes precedence.
  wire ser_fuse_wr = serial_prog_mode & serial_fuse_wr & fuse_wr_ok & ~par_fuse_wr;

  // Read mux for the output-enable strobe, by byte selects and command.
  reg [7:0] rd_next;
  always @* begin
    // Unused addresses and byte selects read as all ones, like an erased cell.
    rd_next = 8'hFF;
    case (cmd_reg)
      `FSP_CMD_RD_SIG: begin
        if (bs1_s)
          rd_next = (addr_lo_reg == `FSP_SIG_ADDR0) ? CALIB_BYTE : 8'hFF;
        else if (addr_lo_reg == `FSP_SIG_ADDR0)
          rd_next = SIG_BYTE0;
        else if (addr_lo_reg == `FSP_SIG_ADDR1)
          rd_next = SIG_BYTE1;
        else if (addr_lo_reg == `FSP_SIG_ADDR2)
          rd_next = SIG_BYTE2;
        else
          rd_next = 8'hFF;
      end
      `FSP_CMD_RD_FUSE: begin
        if (bs2_s)
          rd_next = 8'hFF;
        else if (bs1_s)
          rd_next = fuse_high_cell_reg;
        else
          rd_next = fuse_low_cell_reg;
      end
      default: rd_next = 8'hFF;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      xtal_d_reg          <= 1'b0;
      wr_n_d_reg          <= 1'b1;
      oe_n_d_reg          <= 1'b1;
      pgl_d_reg           <= 1'b0;
      pm_d_reg            <= 1'b0;
      cmd_reg             <= 8'h00;
      addr_lo_reg         <= 8'h00;
      data_lo_reg         <= 8'h00;
      state_reg           <= ST_IDLE;
      busy_cnt_reg        <= 16'h0000;
      ready_busy_out      <= 1'b1;
      data_out            <= 8'hFF;
      data_oe             <= 1'b0;
      chip_erase_pulse    <= 1'b0;
      eeprom_erase_pulse  <= 1'b0;
      page_load_pulse     <= 1'b0;
      osc_calibration_reg <= CALIB_BYTE;
      started_reg         <= 1'b0;
    end else begin
      xtal_d_reg         <= xtal_s;
      wr_n_d_reg         <= wr_n_s;
      oe_n_d_reg         <= oe_n_s;
      pgl_d_reg          <= pgl_s;
      pm_d_reg           <= pm_s;
      chip_erase_pulse   <= 1'b0;
      eeprom_erase_pulse <= 1'b0;
      page_load_pulse    <= pm_s & pgl_rise;
      started_reg        <= 1'b1;
      if (pm_s && xtal_rise) begin
        case ({xa_hi_s, xa_lo_s})
          `FSP_ACT_ADDR: if (!bs1_s) addr_lo_reg <= din_s;
          `FSP_ACT_DATA: if (!bs1_s) data_lo_reg <= din_s;
          `FSP_ACT_CMD:  cmd_reg <= din_s;
          default:       cmd_reg <= cmd_reg;
        endcase
      end
      // Output drive only while output enable is held low.
      data_oe <= pm_s & ~oe_n_s;
      // Refreshed every cycle that OE is low, so a byte-select change shows without a new strobe.
      if (pm_s && (oe_fall || !oe_n_s))
        data_out <= rd_next;
      case (state_reg)
        ST_IDLE: begin
          if (erase_go || par_fuse_wr) begin
            state_reg      <= ST_BUSY;
            busy_cnt_reg   <= PROG_CYCLES[15:0];
            ready_busy_out <= 1'b0;
            if (erase_go) begin
              chip_erase_pulse   <= 1'b1;
              eeprom_erase_pulse <= fuse_high_cell_reg[`FSP_FH_KEEP_BIT];
            end
          end
        end
        ST_BUSY: begin
          // Ending the count at one shows busy for exactly PROG_CYCLES cycles.
          if (busy_cnt_reg <= 16'h0001) begin
            state_reg      <= ST_IDLE;
            ready_busy_out <= 1'b1;
          end else begin
            busy_cnt_reg <= busy_cnt_reg - 16'h0001;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Fuse cells: never touched by chip erase, only by fuse writes.
  always @(posedge clk) begin
    if (!rst_n) begin
      fuse_high_cell_reg <= `FSP_FH_RESET;
      fuse_low_cell_reg  <= `FSP_FL_RESET;
    end else if (par_fuse_wr) begin
      if (bs1_s)
        fuse_high_cell_reg <= data_lo_reg;
      else
        fuse_low_cell_reg <= data_lo_reg;
    end else if (ser_fuse_wr) begin
      // Serial mode may rewrite everything except its own enable bit.
      if (serial_fuse_high)
        fuse_high_cell_reg <= {serial_fuse_data[7:6], fuse_high_cell_reg[`FSP_FH_SERIAL_BIT],
                               serial_fuse_data[4:0]};
      else
        fuse_low_cell_reg <= serial_fuse_data;
    end
  end

  // Latched copies: loaded after reset release and on programming entry.
  always @(posedge clk) begin
    if (!rst_n) begin
      config_fuse_high <= `FSP_FH_RESET;
      config_fuse_low  <= `FSP_FL_RESET;
    end else if (!started_reg || pm_enter) begin
      config_fuse_high <= fuse_high_cell_reg;
      config_fuse_low  <= fuse_low_cell_reg;
    end
  end

  // Debug, scan, serial and watchdog controls are active when the fuse reads zero; boot and reset vector pass through.
  always @(posedge clk) begin
    if (!rst_n) begin
      debug_enable        <= 1'b0;
      scan_port_enable    <= 1'b1;
      serial_prog_enable  <= 1'b1;
      watchdog_force_on   <= 1'b0;
      boot_size           <= 2'h0;
      reset_vector_select <= 1'b1;
    end else begin
      debug_enable        <= ~config_fuse_high[`FSP_FH_DEBUG_BIT];
      scan_port_enable    <= ~config_fuse_high[`FSP_FH_SCAN_BIT];
      serial_prog_enable  <= ~config_fuse_high[`FSP_FH_SERIAL_BIT];
      watchdog_force_on   <= ~config_fuse_high[`FSP_FH_WDOG_BIT];
      boot_size           <= {config_fuse_high[`FSP_FH_BOOT_HI_BIT], config_fuse_high[`FSP_FH_BOOT_LO_BIT]};
      reset_vector_select <= config_fuse_high[`FSP_FH_RSTVEC_BIT];
    end
  end

  // Low byte decode; the clock source field passes through as stored.
  always @(posedge clk) begin
    if (!rst_n) begin
      clock_div_eight     <= 1'b1;
      clock_out_enable    <= 1'b0;
      startup_time        <= 2'h2;
      clock_source        <= 4'h2;
    end else begin
      clock_div_eight     <= ~config_fuse_low[`FSP_FL_DIV8_BIT];
      clock_out_enable    <= ~config_fuse_low[`FSP_FL_CLOCK_OUT_FUSE_BIT];
      startup_time        <= {config_fuse_low[`FSP_FL_SUT_HI_BIT], config_fuse_low[`FSP_FL_SUT_LO_BIT]};
      clock_source        <= config_fuse_low[3:0];
    end
  end
endmodule

/* File: fsp_fuse_port_props.sv */
// Checker of the fuse port pin behaviour.
`timescale 1ns/1ps
module fsp_fuse_port_props #(
  parameter [7:0] CALIB_BYTE = 8'h80
) (
  // Watched ports
  input wire       clk,
  input wire       rst_n,
  input wire       prog_mode,
  input wire       write_n,
  input wire       output_enable_n,
  input wire       data_oe,
  input wire       ready_busy_out,
  input wire [7:0] config_fuse_high,
  input wire [7:0] config_fuse_low,
  input wire       debug_enable,
  input wire       clock_div_eight,
  input wire [7:0] osc_calibration_reg
);
  reg [3:0] oe_cnt_reg;
  reg [3:0] pm_cnt_reg;
  // Counters give the pin synchronisers room before bus release and fuse hold are judged.
  always @(posedge clk) begin
    if (!rst_n || !output_enable_n)
      oe_cnt_reg <= 4'h0;
    else if (oe_cnt_reg != 4'hF)
      oe_cnt_reg <= oe_cnt_reg + 4'h1;
    if (!rst_n || !prog_mode)
      pm_cnt_reg <= 4'h0;
    else if (pm_cnt_reg != 4'hF)
      pm_cnt_reg <= pm_cnt_reg + 4'h1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  oe_release_a: assert property (oe_cnt_reg > 4'h5 |-> !data_oe) else $error("bus driven");
  busy_len_a: assert property ($fell(ready_busy_out) |-> !ready_busy_out [*3] ##[1:4] ready_busy_out)
    else $error("busy length");
  busy_cause_a: assert property ($fell(ready_busy_out) |-> !write_n) else $error("busy without write");
  fuse_reset_a: assert property ($rose(rst_n) |-> config_fuse_high == 8'h99 && config_fuse_low == 8'h62)
    else $error("fuse defaults");
  calib_reset_a: assert property ($rose(rst_n) |-> osc_calibration_reg == CALIB_BYTE)
    else $error("calibration");
  fuse_hold_a: assert property (pm_cnt_reg > 4'h7 |-> $stable(config_fuse_high) && $stable(config_fuse_low))
    else $error("fuse moved");
  debug_map_a: assert property (debug_enable == !$past(config_fuse_high[7])) else $error("debug map");
  div8_map_a: assert property (clock_div_eight == !$past(config_fuse_low[7])) else $error("div8 map");
endmodule
bind fsp_fuse_port fsp_fuse_port_props #(.CALIB_BYTE(CALIB_BYTE)) u_props (.clk(clk), .rst_n(rst_n),
  .prog_mode(prog_mode), .write_n(write_n), .output_enable_n(output_enable_n), .data_oe(data_oe),
  .ready_busy_out(ready_busy_out), .config_fuse_high(config_fuse_high), .config_fuse_low(config_fuse_low),
  .debug_enable(debug_enable), .clock_div_eight(clock_div_eight), .osc_calibration_reg(osc_calibration_reg));

/* File: fsp_prog_model.sv */
// Behavioural parallel programmer for the fuse port.
`timescale 1ns/1ps
module fsp_prog_model (
  // Clock and device answers
  input  wire       clk,
  input  wire       ready_busy_out,
  input  wire [7:0] data_out,
  input  wire       data_oe,
  // Programmer pins
  output reg        crystal_in_strobe,
  output reg        action_select_hi,
  output reg        action_select_lo,
  output reg        byte_select_one,
  output reg        byte_select_two,
  output reg        page_load_strobe,
  output reg        write_n,
  output reg        output_enable_n,
  output reg  [7:0] data_in
);
  reg       saw_busy;
  reg       rd_oe;
  reg [7:0] rd_byte;
  integer   i;
  initial begin
    {crystal_in_strobe, action_select_hi, action_select_lo, byte_select_one} = 4'h6;
    {byte_select_two, page_load_strobe, write_n, output_enable_n} = 4'h3;
    data_in = 8'h00;
    saw_busy = 1'b0;
  end
  task step(input integer n);
    begin
      repeat (n) @(posedge clk);
      #2;
    end
  endtask
  // Every strobe level is held ten cycles, 250 ns at 40 MHz.
  task load(input [1:0] act, input [7:0] val, input bs);
    begin
      {action_select_hi, action_select_lo} = act;
      byte_select_one = bs;
      data_in = val;
      step(10);
      crystal_in_strobe = 1'b1;
      step(10);
      crystal_in_strobe = 1'b0;
      step(10);
    end
  endtask
  task wr(input bs);
    begin
      saw_busy = 1'b0;
      byte_select_one = bs;
      step(10);
      write_n = 1'b0;
      for (i = 0; i < 80; i = i + 1) begin
        step(1);
        saw_busy = saw_busy | !ready_busy_out;
        if (i == 9)
          write_n = 1'b1;
        if (i > 9 && ready_busy_out === 1'b1)
          i = 80;
      end
    end
  endtask
  // The inverted byte stands in for a released bus, so a stale value cannot pass.
  task rd(input bs);
    begin
      byte_select_one = bs;
      data_in = ~data_in;
      step(4);
      output_enable_n = 1'b0;
      step(10);
      rd_byte = data_out;
      rd_oe = data_oe;
      output_enable_n = 1'b1;
      step(8);
    end
  endtask
endmodule

/* File: test_fsp_fuse_port.sv */
// Self-checking bench for the fuse port through the programmer model.
`timescale 1ns/1ps
`include "fsp_regs.vh"
module test_fsp_fuse_port;
  localparam [23:0] SIG = 24'h47D26B; // Arbitrary values.
  localparam [7:0]  CAL = 8'h9E;
  reg        clk;
  reg        rst_n;
  reg        prog_mode;
  reg        serial_prog_mode;
  reg        serial_fuse_wr;
  reg        serial_fuse_high;
  reg  [7:0] serial_fuse_data;
  reg        lock_bit_one;
  wire       st, sh, sl, b_one, b_two, pg, wr_n, oe_n, oe, rdy;
  wire       dbg, scan, ser, wdg, div8, clock_out_fuse, rv;
  wire [1:0] bsz, sut;
  wire [3:0] csrc;
  wire [7:0] din, dout, fh, fl, osc;
  integer    i;
  integer    miscompares;
  integer    checked;
  fsp_prog_model pm (.clk(clk), .ready_busy_out(rdy), .data_out(dout), .data_oe(oe), .crystal_in_strobe(st),
    .action_select_hi(sh), .action_select_lo(sl), .byte_select_one(b_one), .byte_select_two(b_two),
    .page_load_strobe(pg), .write_n(wr_n), .output_enable_n(oe_n), .data_in(din));
  fsp_fuse_port #(.SIG_BYTE0(SIG[7:0]), .SIG_BYTE1(SIG[15:8]), .SIG_BYTE2(SIG[23:16]), .CALIB_BYTE(CAL),
    .PROG_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n), .prog_mode(prog_mode), .serial_prog_mode(serial_prog_mode),
    .crystal_in_strobe(st), .action_select_hi(sh), .action_select_lo(sl), .byte_select_one(b_one),
    .byte_select_two(b_two), .page_load_strobe(pg), .write_n(wr_n), .output_enable_n(oe_n), .data_in(din),
    .data_out(dout), .data_oe(oe), .ready_busy_out(rdy), .serial_fuse_wr(serial_fuse_wr),
    .serial_fuse_high(serial_fuse_high), .serial_fuse_data(serial_fuse_data), .lock_bit_one(lock_bit_one),
    .chip_erase_pulse(), .eeprom_erase_pulse(), .page_load_pulse(), .config_fuse_high(fh),
    .config_fuse_low(fl), .debug_enable(dbg), .scan_port_enable(scan), .serial_prog_enable(ser),
    .watchdog_force_on(wdg), .boot_size(bsz), .reset_vector_select(rv), .clock_div_eight(div8),
    .clock_out_enable(clock_out_fuse), .startup_time(sut), .clock_source(csrc), .osc_calibration_reg(osc));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task prog(input [7:0] cmd, input [7:0] val, input bs);
    begin
      pm.load(`FSP_ACT_CMD, cmd, 1'b0);
      pm.load(`FSP_ACT_ADDR, 8'h00, 1'b0);
      pm.load(`FSP_ACT_DATA, val, 1'b0);
      pm.wr(bs);
    end
  endtask
  task reenter;
    begin
      prog_mode = 1'b0;
      pm.step(12);
      prog_mode = 1'b1;
      pm.step(12);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #2000000;
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    miscompares = 0;
    checked = 0;
    {rst_n, prog_mode, serial_prog_mode, serial_fuse_wr, serial_fuse_high, lock_bit_one} = 6'h11;
    serial_fuse_data = 8'h00;
    repeat (16) @(posedge clk);
    #2;
    rst_n = 1'b1;
    pm.step(4);
    check(fh, 8'h99);
    check(fl, 8'h62);
    check({dbg, scan, ser, wdg, div8, clock_out_fuse, 2'h0}, 8'h68);
    check(osc, CAL);
    check({2'h0, bsz, 1'b0, rv, sut}, 8'h06);
    check({4'h0, csrc}, 8'h02);
    $display("test reset done");
    lock_bit_one = 1'b0;
    pm.load(`FSP_ACT_CMD, `FSP_CMD_RD_SIG, 1'b0);
    for (i = 0; i < 3; i = i + 1) begin
      pm.load(`FSP_ACT_ADDR, i[7:0], 1'b0);
      pm.rd(1'b0);
      check(pm.rd_byte, SIG[i*8 +: 8]);
      check({7'h00, pm.rd_oe}, 8'h01);
    end
    pm.load(`FSP_ACT_ADDR, 8'h00, 1'b0);
    pm.rd(1'b1);
    check(pm.rd_byte, CAL);
    check({7'h00, oe}, 8'h00);
    $display("test signature done");
    prog(`FSP_CMD_WR_FUSE, 8'h00, 1'b0);
    reenter;
    check(fl, 8'h62);
    lock_bit_one = 1'b1;
    prog(`FSP_CMD_WR_FUSE, 8'h18, 1'b1);
    check({7'h00, pm.saw_busy}, 8'h01);
    check(fh, 8'h99);
    prog(`FSP_CMD_ERASE, 8'h00, 1'b0);
    check({7'h00, pm.saw_busy}, 8'h01);
    reenter;
    check(fh, 8'h18);
    check({6'h00, dbg, wdg}, 8'h02);
    check({2'h0, bsz, 1'b0, rv, sut}, 8'h02);
    pm.load(`FSP_ACT_CMD, `FSP_CMD_RD_FUSE, 1'b0);
    pm.rd(1'b1);
    check(pm.rd_byte, 8'h18);
    pm.rd(1'b0);
    check(pm.rd_byte, 8'h62);
    $display("test fuse write done");
    {serial_prog_mode, serial_fuse_high} = 2'h3;
    serial_fuse_data = 8'h3C;
    serial_fuse_wr = 1'b1;
    pm.step(1);
    serial_fuse_wr = 1'b0;
    reenter;
    check(fh, 8'h1C);
    $display("test serial write done");
    wrap_up;
  end
endmodule
